// ### hw/tsfc_regs.vh
`ifndef TSFC_REGS_VH
`define TSFC_REGS_VH
// ----------------------------------------------------------------
// register word addresses (byte address = index * 4)
// ----------------------------------------------------------------
`define TSFC_ADR_FUNC      4'h0
`define TSFC_ADR_PRIO_LO   4'h1
`define TSFC_ADR_PRIO_HI   4'h2
`define TSFC_ADR_ERR_STAT  4'h3
`define TSFC_ADR_POS       4'h4
`define TSFC_ADR_STATUS    4'h5
`define TSFC_ADR_IRQ_STAT  4'h6
`define TSFC_ADR_IRQ_MASK  4'h7
// ----------------------------------------------------------------
// function control setting fields
// ----------------------------------------------------------------
`define TSFC_FC_SIM        0
`define TSFC_FC_EVAL       1
`define TSFC_FC_TBASE      2
`define TSFC_FC_CHG        3
`define TSFC_FC_OUTSEL     4
`define TSFC_FC_DYN        5
`define TSFC_FC_RESET      8'h00
// ----------------------------------------------------------------
// priority codes, two bits per error
// ----------------------------------------------------------------
`define TSFC_PRI_MASKED    2'h0
`define TSFC_PRI_MINOR     2'h1
`define TSFC_PRI_MAJOR     2'h2
// ----------------------------------------------------------------
// position field limits
// ----------------------------------------------------------------
`define TSFC_LAT_DEG_MAX   8'h89
`define TSFC_LON_DEG_MAX   12'h179
`define TSFC_MIN_MAX       8'h59
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TSFC_CLK_HZ        100000000
`define TSFC_SIM_HOURS     4
`define TSFC_PULSE_LONG_MS 980
`define TSFC_PULSE_SHORT_MS 20
`define TSFC_MS_CYCLES     (`TSFC_CLK_HZ / 1000)
`endif

// ### hw/tsfc_top.v
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`include "tsfc_regs.vh"

module tsfc_top #(
  parameter [63:0] SIM_CYCLES = 64'd1440000000000,
  parameter [31:0] MS_CYCLES  = `TSFC_MS_CYCLES,
  parameter        MULTI_SRC  = 1'b1
) (
  // clock and synchronous reset
  input  wire        clk_i,
  input  wire        rst_i,

  // classic wishbone register slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        irq_o,

  // far side levels, asynchronous to clk_i
  input  wire        pps_i,
  input  wire [15:0] err_i,
  input  wire        free_running_oscillator_mode_i,
  input  wire        src_synced_i,
  input  wire        multi_src_i,

  // decoded controls, all registered
  output reg         front_connector_o,
  output reg         auto_changeover_o,
  output reg         tbase_utc_o,
  output reg         use_string_status_o,
  output reg         radio_sync_o,
  output reg         sim_active_o,
  output reg         err_flag_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg  [17:0] sync1_r;
  reg  [17:0] sync2_r;
  wire [15:0] err_s    = sync2_r[15:0];
  wire        pps_s    = sync2_r[16];
  wire        osc_s    = sync2_r[17];
  reg  [1:0]  ms_sync1_r;
  reg  [1:0]  ms_sync2_r;
  wire        synced_s = ms_sync2_r[0];
  wire        multi_s  = ms_sync2_r[1];
  // every far side input is a level or a slow pulse, so plain two flop
  // synchronisers suffice; the pulse output lags the pin by three cycles

  always @(posedge clk_i)
  begin
    sync1_r    <= {free_running_oscillator_mode_i, pps_i, err_i};
    sync2_r    <= sync1_r;
    ms_sync1_r <= {multi_src_i, src_synced_i};
    ms_sync2_r <= ms_sync1_r;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // software visible state
  reg  [7:0]  func_r;
  reg  [31:0] prio_r;
  reg  [32:0] pos_r;
  reg         pos_err_r;
  reg  [3:0]  irq_stat_r;
  reg  [3:0]  irq_mask_r;
  // radio status simulation
  reg         sim_r;
  reg         sim_hold_r;
  reg  [63:0] sim_cnt_r;
  // one second pattern timebase
  reg  [31:0] ms_cnt_r;
  reg  [9:0]  ms_in_s_r;
  // previous values for the rise detectors
  reg         err_any_d_r;
  reg         major_d_r;
  reg         sim_d_r;

  wire        acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr    = acc & wb_we_i;
  wire        rd    = acc & ~wb_we_i;
  wire [3:0]  idx   = wb_adr_i[5:2];

  // position word: [31] north/south, [30:23] latitude degrees bcd,
  // [22:15] latitude minutes bcd, [14:3] longitude degrees bcd, [2:0] spare
  // limitation: longitude sign and minutes have no room in this word
  wire [7:0]  lat_deg = wb_dat_i[30:23];
  wire [7:0]  lat_min = wb_dat_i[22:15];
  wire [11:0] lon_deg = wb_dat_i[14:3];
  // each nibble must be a decimal digit, else 8'h4A would pass under 8'h59
  wire        bcd_ok  = (lat_deg[7:4] <= 4'h9) && (lat_deg[3:0] <= 4'h9)
                        && (lat_min[7:4] <= 4'h9) && (lat_min[3:0] <= 4'h9)
                        && (lon_deg[11:8] <= 4'h9) && (lon_deg[7:4] <= 4'h9)
                        && (lon_deg[3:0] <= 4'h9);
  wire        pos_ok  = bcd_ok && (lat_deg <= `TSFC_LAT_DEG_MAX) && (lat_min <= `TSFC_MIN_MAX)
                        && (lon_deg <= `TSFC_LON_DEG_MAX);
  // only a full word write is taken, a partial one would mix old and new fields
  wire        pos_wr     = wr && (idx == `TSFC_ADR_POS);
  wire        pos_refuse = pos_wr && !(pos_ok && (wb_sel_i == 4'hF));

  // ----------------------------------------------------------------
  // error aggregation
  // ----------------------------------------------------------------
  reg  [15:0] minor_v;
  reg  [15:0] major_v;
  integer     i;
  always @*
  begin
    minor_v = 16'h0000;
    major_v = 16'h0000;
    for (i = 0; i < 16; i = i + 1)
    begin
      minor_v[i] = err_s[i] & (prio_r[2*i +: 2] == `TSFC_PRI_MINOR);
      major_v[i] = err_s[i] & (prio_r[2*i +: 2] == `TSFC_PRI_MAJOR);
    end
  end
  // priority code 3 is unused and, like 0, keeps the error out
  // of the common message
  wire err_any = |minor_v | |major_v;
  wire err_maj = |major_v;

  // ----------------------------------------------------------------
  // bus slave and control state
  // ----------------------------------------------------------------
  wire sim_end = osc_s ? 1'b0 : (sim_cnt_r >= SIM_CYCLES - 64'd1);
  // event bits: 3 position refused, 2 simulation start,
  // 1 major error rises, 0 any unmasked error rises
  // the refusal is taken from the write itself, not from the stored flag,
  // so the very first refused entry already raises its event
  wire [3:0] ev = {pos_refuse,
                   sim_r & ~sim_d_r,
                   err_maj & ~major_d_r,
                   err_any & ~err_any_d_r};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      func_r      <= `TSFC_FC_RESET;
      prio_r      <= 32'h0000_0000;
      pos_r       <= 33'h0_0000_0000;
      pos_err_r   <= 1'b0;
      irq_mask_r  <= 4'h0;
      sim_r       <= 1'b0;
      sim_hold_r  <= 1'b0;
      sim_cnt_r   <= 64'h0;
      wb_ack_o    <= 1'b0;
      err_any_d_r <= 1'b0;
      major_d_r   <= 1'b0;
      sim_d_r     <= 1'b0;
    end
    else
    begin
      wb_ack_o    <= acc;
      err_any_d_r <= err_any;
      major_d_r   <= err_maj;
      sim_d_r     <= sim_r;
      if (sim_r && !sim_hold_r)
      begin
        // 64 bits cover four hours at 100 MHz with a wide margin;
        // the counter stops at the limit so it can never wrap
        // once the window lapses in oscillator mode the status stays until reset
        if (sim_end)
        begin
          sim_r <= 1'b0;
        end
        else
        begin
          sim_cnt_r <= sim_cnt_r + 64'd1;
        end
        if (osc_s && sim_cnt_r >= SIM_CYCLES - 64'd1)
        begin
          sim_hold_r <= 1'b1;
        end
      end
      if (wr)
      begin
        case (idx)
          `TSFC_ADR_FUNC:
          begin
            if (wb_sel_i[0])
            begin
              func_r <= wb_dat_i[7:0];
              // only a 0 to 1 write starts the window, rewriting 1 leaves
              // the running count alone
              if (wb_dat_i[`TSFC_FC_SIM] && !func_r[`TSFC_FC_SIM])
              begin
                sim_r     <= 1'b1;
                sim_cnt_r <= 64'h0;
              end
              if (!wb_dat_i[`TSFC_FC_SIM] && !sim_hold_r)
              begin
                sim_r <= 1'b0;
              end
            end
          end
          // a group left unselected keeps its old priorities
          `TSFC_ADR_PRIO_LO:
          begin
            if (wb_sel_i[0]) prio_r[7:0]   <= wb_dat_i[7:0];
            if (wb_sel_i[1]) prio_r[15:8]  <= wb_dat_i[15:8];
          end
          `TSFC_ADR_PRIO_HI:
          begin
            if (wb_sel_i[0]) prio_r[23:16] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) prio_r[31:24] <= wb_dat_i[15:8];
          end
          `TSFC_ADR_POS:
          begin
            // out of range entries are refused and flagged
            if (pos_ok && wb_sel_i == 4'hF)
            begin
              pos_r     <= {wb_dat_i[31:0], 1'b0};
              pos_err_r <= 1'b0;
            end
            else
            begin
              pos_err_r <= 1'b1;
            end
          end
          `TSFC_ADR_IRQ_MASK:
          begin
            if (wb_sel_i[0]) irq_mask_r <= wb_dat_i[3:0];
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, cleared by reading it
  // ----------------------------------------------------------------
  // set wins over the read clear, so an event in the clearing cycle is kept
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= 4'h0;
    end
    else if (rd && idx == `TSFC_ADR_IRQ_STAT)
    begin
      irq_stat_r <= ev;
    end
    else
    begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // data is registered together with the ack and then held until the
  // next read, so a slow master can still pick it up late;
  // unmapped indices read as zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (rd)
    begin
      case (idx)
        `TSFC_ADR_FUNC:     wb_dat_o <= {24'h000000, func_r};
        `TSFC_ADR_PRIO_LO:  wb_dat_o <= {16'h0000, prio_r[15:0]};
        `TSFC_ADR_PRIO_HI:  wb_dat_o <= {16'h0000, prio_r[31:16]};
        `TSFC_ADR_ERR_STAT: wb_dat_o <= {major_v, minor_v};
        `TSFC_ADR_POS:      wb_dat_o <= pos_r[32:1];
        `TSFC_ADR_STATUS:   wb_dat_o <= {26'h0, pos_err_r, sim_hold_r, sim_r, radio_sync_o, err_maj, err_any};
        `TSFC_ADR_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_r};
        `TSFC_ADR_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask_r};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // dynamic error pattern timebase, one second period
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ms_cnt_r  <= 32'h0;
      ms_in_s_r <= 10'h000;
    end
    else if (ms_cnt_r >= MS_CYCLES - 32'd1)
    begin
      ms_cnt_r  <= 32'h0;
      ms_in_s_r <= (ms_in_s_r >= 10'd999) ? 10'h000 : ms_in_s_r + 10'd1;
    end
    else
    begin
      ms_cnt_r <= ms_cnt_r + 32'd1;
    end
  end

  // the pattern runs free from reset and is not aligned to the pulse
  // input; a receiver only needs the duty ratio, not the phase
  wire long_hi  = ms_in_s_r < `TSFC_PULSE_LONG_MS;  // 980 high, 20 low
  wire short_hi = ms_in_s_r < `TSFC_PULSE_SHORT_MS; // 20 high, 980 low
  // major outranks minor; static output is high while any unmasked error stands
  reg  cerr_level;
  always @*
  begin
    if (func_r[`TSFC_FC_DYN])
      cerr_level = err_maj ? 1'b0 : (err_any ? short_hi : long_hi);
    else
      cerr_level = err_any;
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      front_connector_o   <= 1'b0;
      auto_changeover_o   <= 1'b1;
      tbase_utc_o         <= 1'b0;
      use_string_status_o <= 1'b1;
      radio_sync_o        <= 1'b0;
      sim_active_o        <= 1'b0;
      err_flag_o          <= 1'b0;
    end
    else
    begin
      // every control follows the setting one cycle after the write
      front_connector_o   <= func_r[`TSFC_FC_OUTSEL] ? cerr_level : pps_s;
      // single source systems always switch automatically
      auto_changeover_o   <= ~(MULTI_SRC & multi_s & func_r[`TSFC_FC_CHG]);
      tbase_utc_o         <= func_r[`TSFC_FC_EVAL] & func_r[`TSFC_FC_TBASE];
      use_string_status_o <= ~func_r[`TSFC_FC_EVAL];
      radio_sync_o        <= synced_s | sim_r;
      sim_active_o        <= sim_r;
      err_flag_o          <= err_any;
    end
  end

endmodule // tsfc_top

// ### verif/tsfc_props.sv
`timescale 1ns/100ps
module tsfc_props #(
  parameter [63:0] SIM_CYCLES = 64'd200
) (
  input logic        clk_i,
  input logic        rst_i,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [5:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        irq_o,
  input logic        pps_i,
  input logic [15:0] err_i,
  input logic        free_running_oscillator_mode_i,
  input logic        src_synced_i,
  input logic        multi_src_i,
  input logic        front_connector_o,
  input logic        auto_changeover_o,
  input logic        tbase_utc_o,
  input logic        use_string_status_o,
  input logic        radio_sync_o,
  input logic        sim_active_o,
  input logic        err_flag_o
);
  logic [63:0] sim_cnt_r;
  logic [3:0]  quiet_r;
  // input synchronisers add latency, so quiet needs a margin
  always @(posedge clk_i)
  begin
    sim_cnt_r <= (rst_i || !sim_active_o) ? 64'h0 : sim_cnt_r + 64'h1;
    quiet_r   <= (rst_i || |err_i) ? 4'h0 : (quiet_r == 4'hF ? 4'hF : quiet_r + 4'h1);
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  unmapped_read_a: assert property ($past(wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[5]) && wb_ack_o
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  reset_values_a: assert property (disable iff (1'b0) rst_i |=> auto_changeover_o && use_string_status_o
    && !sim_active_o && !wb_ack_o && !irq_o) else $error("bad value in reset");
  sim_radio_a: assert property (sim_active_o && $past(sim_active_o) |-> radio_sync_o)
    else $error("simulation without radio status");
  tbase_gate_a: assert property (use_string_status_o |-> !tbase_utc_o)
    else $error("time base used under standard evaluation");
  quiet_flag_a: assert property (quiet_r >= 4'h8 |-> !err_flag_o)
    else $error("error flag without error");
  sim_limit_a: assert property (sim_cnt_r > SIM_CYCLES + 64'd8 |-> free_running_oscillator_mode_i)
    else $error("simulation outlived its limit");
  cover property ($rose(sim_active_o));
  cover property ($rose(irq_o));
  cover property ($rose(front_connector_o));
endmodule // tsfc_props
bind tsfc_top tsfc_props #(.SIM_CYCLES(SIM_CYCLES)) u_props (.*);

// ### verif/tsfc_far.sv
`timescale 1ns/100ps
// far side: pulse source, error sources and real sync source
module tsfc_far #(
  parameter PPS_CYC = 500
) (
  input  wire        clk_i,
  input  wire [15:0] err_cmd_i,
  input  wire        sync_cmd_i,
  output reg         pps_o = 1'b0,
  output reg  [15:0] err_o = 16'h0,
  output reg         synced_o = 1'b0
);
  integer cnt = 0;
  always @(posedge clk_i)
  begin
    cnt <= (cnt == PPS_CYC - 1) ? 0 : cnt + 1;
    pps_o <= (cnt < 10);
    err_o <= err_cmd_i;
    synced_o <= sync_cmd_i;
  end
endmodule // tsfc_far

// ### verif/tsfc_top_test.sv
`timescale 1ns/100ps
module tsfc_top_test;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic [15:0] err_i, err_cmd = 0;
  logic        wb_ack_o, irq_o, pps_i, src_synced_i, sync_cmd = 0;
  logic        free_running_oscillator_mode_i = 0, multi_src_i = 1;
  logic        front_connector_o, auto_changeover_o, tbase_utc_o, use_string_status_o;
  logic        radio_sync_o, sim_active_o, err_flag_o;
  logic [31:0] pos = {1'b1, 8'h89, 8'h59, 12'h179, 3'h0};
  integer      err_total = 0, n_checks = 0, c;
  tsfc_top #(.SIM_CYCLES(64'd200), .MS_CYCLES(32'd2)) dut (.*);
  tsfc_far u_far (.clk_i(clk_i), .err_cmd_i(err_cmd), .sync_cmd_i(sync_cmd), .pps_o(pps_i),
    .err_o(err_i), .synced_o(src_synced_i));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] ix, input logic [31:0] d, input logic [3:0] s);
    integer n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'h0};
    wb_sel_i <= s;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      err_total++;
      $display("Error %0t: no bus ack", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  // counts high cycles of the front output over one full second
  task hi_cnt;
    c = 0;
    repeat (10) @(posedge clk_i);
    repeat (2000) @(negedge clk_i) c += front_connector_o;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    print_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 0, 0, 4'hF); chk(rd, 0);
    chk(auto_changeover_o, 1);
    chk(use_string_status_o, 1);
    wb(1, 9, 32'h5, 4'hF); wb(0, 9, 0, 4'hF); chk(rd, 0);
    wb(1, 0, 32'h08, 4'hF); repeat (6) @(posedge clk_i); chk(auto_changeover_o, 0);
    multi_src_i <= 0; repeat (6) @(posedge clk_i); chk(auto_changeover_o, 1);
    multi_src_i <= 1;
    wb(1, 0, 32'h06, 4'hF); repeat (6) @(posedge clk_i); chk(use_string_status_o, 0);
    chk(tbase_utc_o, 1);
    wb(1, 0, 32'h02, 4'hF); repeat (6) @(posedge clk_i); chk(tbase_utc_o, 0);
    wb(1, 0, 32'h04, 4'hF); repeat (6) @(posedge clk_i); chk(tbase_utc_o, 0);
    $display("test function bits done");
    wb(1, 1, 32'h2, 4'hF);
    wb(1, 1, 32'hFF00, 4'h2);
    err_cmd <= 16'h0111;
    repeat (8) @(posedge clk_i);
    wb(0, 3, 0, 4'hF); chk(rd, 32'h0001_0000);
    chk(err_flag_o, 1);
    chk(irq_o, 0);
    wb(1, 7, 32'hF, 4'hF); repeat (2) @(posedge clk_i); chk(irq_o, 1);
    wb(0, 6, 0, 4'hF); chk(rd, 32'h3);
    wb(0, 6, 0, 4'hF); chk(rd, 0);
    chk(irq_o, 0);
    wb(1, 0, 32'h10, 4'hF); repeat (6) @(posedge clk_i); chk(front_connector_o, 1);
    wb(1, 0, 32'h30, 4'hF); hi_cnt; chk(c, 0);
    wb(1, 1, 32'h1, 4'hF); hi_cnt; chk(c, 40);
    err_cmd <= 0; hi_cnt; chk(c, 1960);
    wb(1, 1, 32'h0, 4'hF); err_cmd <= 16'h0001; repeat (8) @(posedge clk_i);
    chk(err_flag_o, 0);
    $display("test errors done");
    wb(1, 4, pos, 4'hF); wb(0, 4, 0, 4'hF); chk(rd, pos);
    wb(1, 4, 32'h4800_0000, 4'hF); wb(0, 4, 0, 4'hF); chk(rd, pos);
    wb(0, 5, 0, 4'hF); chk(rd[5], 1);
    wb(0, 6, 0, 4'hF); chk(rd, 32'h8);
    $display("test position done");
    err_cmd <= 0;
    wb(1, 0, 32'h01, 4'hF); repeat (6) @(posedge clk_i); chk(sim_active_o, 1);
    chk(radio_sync_o, 1);
    repeat (250) @(posedge clk_i); chk(sim_active_o, 0);
    chk(radio_sync_o, 0);
    sync_cmd <= 1; repeat (6) @(posedge clk_i); chk(radio_sync_o, 1);
    sync_cmd <= 0; repeat (6) @(posedge clk_i); chk(radio_sync_o, 0);
    free_running_oscillator_mode_i <= 1;
    wb(1, 0, 0, 4'hF); wb(1, 0, 32'h01, 4'hF);
    repeat (400) @(posedge clk_i); chk(sim_active_o, 1);
    rst_i <= 1; repeat (6) @(posedge clk_i); rst_i <= 0;
    repeat (6) @(posedge clk_i); chk(sim_active_o, 0);
    $display("test simulation done");
    print_verdict;
  end
endmodule // tsfc_top_test
